// ===== include/atc_pkg.sv
/*
 * Constants for the antenna tuning configuration register bank: register
 * indices, field positions, reset value and the sensitivity step.
 * Assumes a single 40 MHz clock domain; no timing figures are needed.
 */
package atc_pkg;

  typedef logic [8:0] atc_word_type;

  // Register indices on the 4-bit configuration address
  localparam logic [3:0] ATC_ADDR_CFG1 = 4'h1;
  localparam logic [3:0] ATC_ADDR_CFG2 = 4'h2;
  localparam logic [3:0] ATC_ADDR_CFG3 = 4'h3;
  localparam logic [3:0] ATC_ADDR_CFG4 = 4'h4;

  localparam atc_word_type ATC_RESET_VALUE = 9'h000;
  // Bits 8-7 of register 3 do not exist
  localparam atc_word_type ATC_CFG3_MASK = 9'h07F;

  // Field positions
  localparam int ATC_PARITY_BIT = 0;
  localparam int ATC_SEL_HI = 8;
  localparam int ATC_SEL_LO = 7;
  localparam int ATC_PULLDOWN_BIT = 8;
  localparam int ATC_DIVIDE_BIT = 7;
  localparam int ATC_TRIM_HI = 6;
  localparam int ATC_TRIM_LO = 1;
  localparam int ATC_XCUT_HI = 8;
  localparam int ATC_XCUT_LO = 5;
  localparam int ATC_YCUT_HI = 4;
  localparam int ATC_YCUT_LO = 1;

  // Output select codes; both 2 and 3 give signal strength
  localparam logic [1:0] ATC_SEL_DEMOD = 2'h0;
  localparam logic [1:0] ATC_SEL_CARRIER = 2'h1;

  // Sensitivity reduction per code step, in dB
  localparam logic [4:0] ATC_GAIN_STEP_DB = 5'h02;

endpackage

// ===== hdl/atc_carrier_div.sv
/*
 * Carrier clock presentation: passes the synchronised carrier straight on
 * or divided by four. Expects carrierSync already in the sys_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module atc_carrier_div (
  input wire logic sys_clk, // 40 MHz clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic carrierSync, // Carrier, already synchronised
  input wire logic divideSel, // 1: divide by four, 0: pass through
  output logic carrierOut // Carrier as presented to the pad mux
);
  import atc_pkg::*;

  logic carrierPrevQ;
  logic [1:0] divCntQ;
  logic carrierOutQ;
  wire logic carrierRise = carrierSync & ~carrierPrevQ;
  // Bit 1 of a counter bumped on every rising edge toggles every two edges
  wire logic carrierOutD = divideSel ? divCntQ[1] : carrierSync;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      carrierPrevQ <= 1'b0;
      divCntQ <= 2'h0;
      carrierOutQ <= 1'b0;
    end else begin
      carrierPrevQ <= carrierSync;
      divCntQ <= carrierRise ? divCntQ + 2'h1 : divCntQ;
      carrierOutQ <= carrierOutD;
    end
  end

  assign carrierOut = carrierOutQ;

  undivided_pass_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !divideSel |=> (carrierOut == $past(carrierSync)))
    else $error("undivided carrier not passed through");

  divided_count_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (divideSel && carrierRise && divCntQ == 2'h1) |=> ##1 carrierOut)
    else $error("divided carrier did not rise after second edge");

endmodule // atc_carrier_div

`default_nettype wire

// ===== hdl/atc_tuning_regs.sv
/*
 * Configuration registers 1 to 4 of the low-frequency front end: output
 * select, carrier divide, strength pull-down, three tuning trims and two
 * sensitivity cuts, plus the data pad output mux.
 * Assumes the serial command decoder drives the cfg* strobes in sys_clk
 * and that demodulated data, carrier and strength level arrive unsynced.
 */
// Function
// - Select field routes data, carrier or strength.
// - Pull-down bit acts only in strength mode.
// - Divide bit presents carrier divided by four.
// - Three six-bit tuning trims, zero to 63 pF.
// - X sensitivity cut in 2 dB steps.
// - Y sensitivity cut on the same scale.
// - Sensitivity cut monotonic in field code.
// - Register 3 bits 8-7 read zero.
// - All implemented bits writable, reset to zero.
// - Host reads and writes configuration registers.
`timescale 1ns/1ps
`default_nettype none

module atc_tuning_regs (
  input wire logic sys_clk, // 40 MHz clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [3:0] cfgAddr, // Register index
  input wire logic cfgWrEn, // Write strobe, one cycle
  input wire atc_pkg::atc_word_type cfgWrData, // Write word
  input wire logic cfgRdEn, // Read strobe, one cycle
  output atc_pkg::atc_word_type cfgRdData, // Read word, registered
  output logic cfgRdValid, // Read word valid, one cycle
  input wire logic demodIn, // Demodulated data, unsynced
  input wire logic carrierIn, // Carrier clock, unsynced
  input wire logic rssiIn, // Strength level, unsynced
  output logic lowfreqDataPad, // Data pad output
  output logic strengthPulldownOn, // Pad pull-down gate
  output logic [5:0] xChannelCapTrim, // X tuning trim
  output logic [5:0] yChannelCapTrim, // Y tuning trim
  output logic [5:0] zChannelCapTrim, // Z tuning trim
  output logic [3:0] xChannelGainCut, // X sensitivity code
  output logic [3:0] yChannelGainCut, // Y sensitivity code
  output logic [4:0] xGainCutDb, // X reduction in dB
  output logic [4:0] yGainCutDb // Y reduction in dB
);
  import atc_pkg::*;

  function automatic logic [4:0] cutToDb(input logic [3:0] code);
    cutToDb = 5'(code * ATC_GAIN_STEP_DB);
  endfunction

  atc_word_type cfg1Q, cfg2Q, cfg3Q, cfg4Q;
  atc_word_type rdDataQ;
  logic rdValidQ;
  logic [1:0] demodSyncQ, carrierSyncQ, rssiSyncQ;
  logic padQ, pulldownQ;
  logic [4:0] xDbQ, yDbQ;
  logic carrierOut;

  // Inputs from the analog side cross two flops before use
  wire logic demodSync = demodSyncQ[1];
  wire logic carrierSync = carrierSyncQ[1];
  wire logic rssiSync = rssiSyncQ[1];

  wire logic wrCfg1 = cfgWrEn && cfgAddr == ATC_ADDR_CFG1;
  wire logic wrCfg2 = cfgWrEn && cfgAddr == ATC_ADDR_CFG2;
  wire logic wrCfg3 = cfgWrEn && cfgAddr == ATC_ADDR_CFG3;
  wire logic wrCfg4 = cfgWrEn && cfgAddr == ATC_ADDR_CFG4;

  // Parity is stored as written; a bad word is the writer's problem
  wire atc_word_type cfg3Wr = cfgWrData & ATC_CFG3_MASK;

  // Other indices belong to neighbouring banks; here they read zero
  wire atc_word_type rdMux =
    (cfgAddr == ATC_ADDR_CFG1) ? cfg1Q :
    (cfgAddr == ATC_ADDR_CFG2) ? cfg2Q :
    (cfgAddr == ATC_ADDR_CFG3) ? cfg3Q :
    (cfgAddr == ATC_ADDR_CFG4) ? cfg4Q : ATC_RESET_VALUE;

  wire logic [1:0] padSel = cfg1Q[ATC_SEL_HI:ATC_SEL_LO];
  wire logic padMux =
    (padSel == ATC_SEL_DEMOD) ? demodSync :
    (padSel == ATC_SEL_CARRIER) ? carrierOut : rssiSync;
  // Pull-down would fight data or carrier, so it is gated by mode
  wire logic pulldownD = cfg2Q[ATC_PULLDOWN_BIT] & padSel[1];
  wire logic [3:0] xCut = cfg4Q[ATC_XCUT_HI:ATC_XCUT_LO];
  wire logic [3:0] yCut = cfg4Q[ATC_YCUT_HI:ATC_YCUT_LO];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg1Q <= ATC_RESET_VALUE;
      cfg2Q <= ATC_RESET_VALUE;
      cfg3Q <= ATC_RESET_VALUE;
      cfg4Q <= ATC_RESET_VALUE;
    end else begin
      cfg1Q <= wrCfg1 ? cfgWrData : cfg1Q;
      cfg2Q <= wrCfg2 ? cfgWrData : cfg2Q;
      cfg3Q <= wrCfg3 ? cfg3Wr : cfg3Q;
      cfg4Q <= wrCfg4 ? cfgWrData : cfg4Q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDataQ <= ATC_RESET_VALUE;
      rdValidQ <= 1'b0;
    end else begin
      rdDataQ <= cfgRdEn ? rdMux : rdDataQ;
      rdValidQ <= cfgRdEn;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      demodSyncQ <= 2'h0;
      carrierSyncQ <= 2'h0;
      rssiSyncQ <= 2'h0;
    end else begin
      demodSyncQ <= {demodSyncQ[0], demodIn};
      carrierSyncQ <= {carrierSyncQ[0], carrierIn};
      rssiSyncQ <= {rssiSyncQ[0], rssiIn};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      padQ <= 1'b0;
      pulldownQ <= 1'b0;
      xDbQ <= 5'h00;
      yDbQ <= 5'h00;
    end else begin
      padQ <= padMux;
      pulldownQ <= pulldownD;
      xDbQ <= cutToDb(xCut);
      yDbQ <= cutToDb(yCut);
    end
  end

  atc_carrier_div carrierDiv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .carrierSync(carrierSync),
    .divideSel(cfg2Q[ATC_DIVIDE_BIT]),
    .carrierOut(carrierOut)
  );

  assign cfgRdData = rdDataQ;
  assign cfgRdValid = rdValidQ;
  assign lowfreqDataPad = padQ;
  assign strengthPulldownOn = pulldownQ;
  assign xChannelCapTrim = cfg1Q[ATC_TRIM_HI:ATC_TRIM_LO];
  assign yChannelCapTrim = cfg2Q[ATC_TRIM_HI:ATC_TRIM_LO];
  assign zChannelCapTrim = cfg3Q[ATC_TRIM_HI:ATC_TRIM_LO];
  assign xChannelGainCut = xCut;
  assign yChannelGainCut = yCut;
  assign xGainCutDb = xDbQ;
  assign yGainCutDb = yDbQ;

  select_demod_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    padSel == ATC_SEL_DEMOD |=> lowfreqDataPad == $past(demodSync))
    else $error("pad does not follow demodulated data");

  select_carrier_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    padSel == ATC_SEL_CARRIER |=> lowfreqDataPad == $past(carrierOut))
    else $error("pad does not follow carrier");

  select_rssi_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    padSel[1] |=> lowfreqDataPad == $past(rssiSync))
    else $error("pad does not follow strength level");

  pulldown_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (padSel[1] && cfg2Q[ATC_PULLDOWN_BIT]) |=> strengthPulldownOn)
    else $error("pull-down not on in strength mode");

  pulldown_block_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !padSel[1] |=> !strengthPulldownOn)
    else $error("pull-down on outside strength mode");

  trim_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wrCfg1 |=> xChannelCapTrim == $past(cfgWrData[6:1]))
    else $error("X trim not taken from write");

  gain_scale_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wrCfg4 |=> ##1 xGainCutDb == 5'($past(cfgWrData[8:5], 2) * 2))
    else $error("X cut not two dB per step");

  gain_monotonic_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (yCut > $past(yCut)) |=> yGainCutDb > $past(yGainCutDb))
    else $error("Y cut not monotonic");

  reg3_unimpl_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (cfgRdEn && cfgAddr == ATC_ADDR_CFG3) |=> cfgRdData[8:7] == 2'h0)
    else $error("register 3 top bits not zero");

  read_back_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (wrCfg2 ##1 (cfgRdEn && cfgAddr == ATC_ADDR_CFG2 && !cfgWrEn))
    |=> cfgRdValid && cfgRdData == $past(cfgWrData, 2))
    else $error("read-back differs from written word");

endmodule // atc_tuning_regs

`default_nettype wire

// ===== tb/atc_host_model.sv
/* Host side model of the tuning register bank's access port.
   Assumes sys_clk from the bench; tasks are called hierarchically. */
`timescale 1ns/1ps
`default_nettype none
module atc_host_model (
  input wire logic sys_clk, // 40 MHz clock
  output logic [3:0] cfgAddr, // Register index
  output logic cfgWrEn, // Write strobe
  output atc_pkg::atc_word_type cfgWrData, // Write word
  output logic cfgRdEn, // Read strobe
  input wire atc_pkg::atc_word_type cfgRdData, // Read word
  input wire logic cfgRdValid // Read valid
);
  import atc_pkg::*;
  initial begin
    cfgAddr = 4'h0;
    cfgWrEn = 1'b0;
    cfgWrData = 9'h000;
    cfgRdEn = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cfgAddr <= a;
    cfgWrData <= {d, ~^d}; // Bit 0 makes the word odd weight
    cfgWrEn <= 1'b1;
    @(posedge sys_clk);
    cfgWrEn <= 1'b0;
    cfgWrData <= ~{d, ~^d}; // Stale word inverted so nobody leans on it
  endtask
  task automatic rd(input logic [3:0] a, output atc_word_type q,
                    output logic v);
    @(posedge sys_clk);
    cfgAddr <= a;
    cfgRdEn <= 1'b1;
    @(posedge sys_clk);
    cfgRdEn <= 1'b0;
    #1;
    q = cfgRdData;
    v = cfgRdValid;
  endtask
  // Write, then read the same index on the very next edge
  task automatic wrrd(input logic [3:0] a, input logic [7:0] d,
                      output atc_word_type q);
    @(posedge sys_clk);
    cfgAddr <= a;
    cfgWrData <= {d, ~^d};
    cfgWrEn <= 1'b1;
    @(posedge sys_clk);
    cfgWrEn <= 1'b0;
    cfgRdEn <= 1'b1;
    @(posedge sys_clk);
    cfgRdEn <= 1'b0;
    #1;
    q = cfgRdData;
  endtask
endmodule // atc_host_model
`default_nettype wire

// ===== tb/tb_atc_tuning_regs.sv
/* Self-checking bench for the tuning register bank.
   Assumes the host model file is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_atc_tuning_regs;
  import atc_pkg::*;
  logic sys_clk, rst_n, demodIn, carrierIn, rssiIn, cfgWrEn, cfgRdEn;
  logic [3:0] cfgAddr, xC, yC;
  atc_word_type cfgWrData, cfgRdData, q, exp9;
  logic cfgRdValid, pad, pullOn, v, padQ;
  logic [5:0] xT, yT, zT;
  logic [4:0] xD, yD;
  logic [7:0] wd [1:4];
  int num_errors, n_tests, k, cnt0;
  int cnt = 0;
  atc_host_model atc_host_model_i (.sys_clk(sys_clk), .cfgAddr(cfgAddr),
    .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .cfgRdEn(cfgRdEn),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid));
  atc_tuning_regs atc_tuning_regs_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData),
    .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .demodIn(demodIn), .carrierIn(carrierIn), .rssiIn(rssiIn),
    .lowfreqDataPad(pad), .strengthPulldownOn(pullOn),
    .xChannelCapTrim(xT), .yChannelCapTrim(yT), .zChannelCapTrim(zT),
    .xChannelGainCut(xC), .yChannelGainCut(yC), .xGainCutDb(xD),
    .yGainCutDb(yD));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Counts pad rising edges in every mode; the carrier checks use differences
  always @(posedge sys_clk) begin
    padQ <= pad;
    if (pad & ~padQ) cnt <= cnt + 1;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    #200us;
    num_errors++;
    summarize;
  end
  initial begin
    rst_n = 1'b0;
    demodIn = 1'b0;
    carrierIn = 1'b0;
    rssiIn = 1'b0;
    num_errors = 0;
    n_tests = 0;
    wd = '{8'h2A, 8'h15, 8'hFF, 8'hA5};
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (k = 1; k <= 5; k++) begin
      atc_host_model_i.rd(k[3:0], q, v);
      chk(q, 9'h000);
      chk({8'h00, v}, 9'h001);
    end
    for (k = 0; k <= 5; k++) begin
      atc_host_model_i.wr(k[3:0], wd[(k > 0 && k < 5) ? k : 3]);
    end
    for (k = 1; k <= 4; k++) begin
      atc_host_model_i.rd(k[3:0], q, v);
      exp9 = {wd[k], ~^wd[k]} & (k == 3 ? ATC_CFG3_MASK : 9'h1FF);
      chk(q, exp9);
    end
    atc_host_model_i.rd(4'h0, q, v);
    chk(q, 9'h000);
    chk({xT, yT[5:3]}, {6'h2A, 3'h2});
    chk({yT[2:0], zT}, {3'h5, 6'h3F});
    atc_host_model_i.wrrd(4'h2, 8'h5B, q);
    chk(q, 9'h0B6);
    for (k = 0; k < 16; k++) begin
      atc_host_model_i.wr(4'h4, {k[3:0], ~k[3:0]});
      settle(1);
      chk({1'b0, xC, yC}, {1'b0, k[3:0], ~k[3:0]});
      chk({xD, 4'h0}, {k[3:0], 5'h00});
      chk({yD, 4'h0}, {~k[3:0], 5'h00});
    end
    atc_host_model_i.wr(4'h2, 8'h80);
    for (k = 0; k < 4; k++) begin
      atc_host_model_i.wr(4'h1, {k[1:0], 6'h00});
      demodIn <= 1'b1;
      rssiIn <= 1'b0;
      settle(5);
      chk({8'h00, pad}, {8'h00, k == 0});
      chk({8'h00, pullOn}, {8'h00, k[1]});
      demodIn <= 1'b0;
      rssiIn <= 1'b1;
      settle(5);
      chk({8'h00, pad}, {8'h00, k[1]});
    end
    atc_host_model_i.wr(4'h1, 8'h40);
    for (k = 0; k < 2; k++) begin
      atc_host_model_i.wr(4'h2, {1'b0, k[0], 6'h00});
      settle(8);
      cnt0 = cnt;
      repeat (32) begin
        repeat (4) @(posedge sys_clk) carrierIn <= 1'b1;
        repeat (4) @(posedge sys_clk) carrierIn <= 1'b0;
      end
      settle(10);
      // Divider count is a multiple of four here, so 32 rises undivided and exactly 8 divided
      if (k == 0) chk(9'(cnt - cnt0), 9'h020);
      else chk(9'(cnt - cnt0), 9'h008);
    end
    summarize;
  end
endmodule // tb_atc_tuning_regs
`default_nettype wire
